//--- hw/mbd_pkg.sv
package mbd_pkg;
    // ==================================================
    // Timing
    // ==================================================
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned BIT_RATE = 250_000;
    localparam int unsigned BIT_CYC = CLK_HZ / BIT_RATE;
    localparam int unsigned ED_PERIOD_US = 40;
    localparam int unsigned ED_CYC = ED_PERIOD_US * (CLK_HZ / 1_000_000);
    // Protocol intervals, counted in bit periods (4 bits per symbol).
    localparam logic [15:0] BO_TICKS = 16'h0050;
    localparam logic [15:0] CCA_TICKS = 16'h0020;
    localparam logic [15:0] TURN_TICKS = 16'h0030;
    localparam logic [15:0] ACKW_TICKS = 16'h00d8;
    localparam logic [2:0] MIN_BE = 3'h3;
    localparam logic [2:0] MAX_BE = 3'h5;
    localparam logic [2:0] MAX_NB = 3'h4;
    // ==================================================
    // Register map, word index on the register port
    // ==================================================
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_TXCFG = 8'h01;
    localparam logic [7:0] REG_DEST = 8'h02;
    localparam logic [7:0] REG_TIMER = 8'h03;
    localparam logic [7:0] REG_EDTHR = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h05;
    localparam logic [7:0] REG_FCTL = 8'h06;
    localparam logic [1:0] WIN_TXBUF = 2'h1;
    localparam logic [1:0] WIN_RXBUF = 2'h2;
    localparam int unsigned BUF_DEPTH = 64;
    // Control bit positions.
    localparam int CTL_RX_ON = 0;
    localparam int CTL_RXDIV = 1;
    localparam int CTL_TXDIV = 2;
    localparam int CTL_AUTOACK = 3;
    localparam int CTL_IRQ_RX = 4;
    localparam int CTL_IRQ_ACK = 5;
    localparam int CTL_INV_EN = 6;
    localparam int CTL_CCA_LSB = 8;
    // Status bits cleared by writing one.
    localparam int ST_TX_OK = 1;
    localparam int ST_TX_FAIL = 2;
    localparam int ST_RX_DONE = 3;
    // Frame layout.
    localparam logic [6:0] HDR_BYTES = 7'h05;
    localparam logic [6:0] ACK_BYTES = 7'h03;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [2:0] FT_ACK = 3'h2;
    localparam int FC_ACKREQ = 5;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [7:0] EDTHR_RST = 8'h40;

    typedef enum logic [1:0] {CCA_ED_OR_CS, CCA_ED, CCA_CS, CCA_ED_AND_CS} mbd_cca_t;
    typedef enum {ST_IDLE, ST_BACKOFF, ST_CCA, ST_TURN, ST_TX, ST_ACKWAIT} mbd_state_t;
endpackage : mbd_pkg

//--- hw/mbd_baseband.sv
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module mbd_baseband (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rstn_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // Modem transmit side
    output logic tx_on_o,
    output logic tx_bit_o,
    output logic tx_bit_vld_o,
    // Modem receive side
    input wire logic rx_bit_i,
    input wire logic rx_bit_vld_i,
    input wire logic rx_busy_i,
    input wire logic rx_end_i,
    input wire logic [7:0] lqi_i,
    input wire logic preamble_ok_i,
    input wire logic cca_ed_i,
    input wire logic cca_cs_i,
    // Energy detection
    output logic ed_req_o,
    input wire logic ed_valid_i,
    input wire logic [7:0] ed_level_i,
    // Interrupts and antenna switch
    output logic irq_rx_o,
    output logic irq_ack_o,
    output logic antenna_select_primary_o,
    output logic antenna_select_inverse_o
);
    // ==================================================
    // Registers and buffers
    // ==================================================
    logic [31:0] ctrl_r;
    logic [31:0] txcfg_r;
    logic [15:0] dest_r;
    logic [15:0] fctl_r;
    logic [7:0] edthr_r;
    logic [15:0] tmr_r;
    logic tmr_arm_r;
    logic tx_req_r;
    logic tx_ok_r;
    logic tx_fail_r;
    logic rx_done_r;
    logic crc_ok_r;
    logic [7:0] lqi_r;
    logic [6:0] rx_len_r;
    logic [7:0] txbuf [mbd_pkg::BUF_DEPTH];
    logic [7:0] rxbuf [mbd_pkg::BUF_DEPTH];

    wire sel_word = (reg_addr_i[7:6] == 2'h0);
    wire wr_ctrl = reg_wr_i && sel_word && reg_addr_i == mbd_pkg::REG_CTRL;
    wire wr_txcfg = reg_wr_i && reg_addr_i == mbd_pkg::REG_TXCFG;
    wire wr_dest = reg_wr_i && reg_addr_i == mbd_pkg::REG_DEST;
    wire wr_tmr = reg_wr_i && reg_addr_i == mbd_pkg::REG_TIMER;
    wire wr_thr = reg_wr_i && reg_addr_i == mbd_pkg::REG_EDTHR;
    wire wr_stat = reg_wr_i && reg_addr_i == mbd_pkg::REG_STATUS;
    wire wr_fctl = reg_wr_i && reg_addr_i == mbd_pkg::REG_FCTL;
    wire wr_txbuf = reg_wr_i && reg_addr_i[7:6] == mbd_pkg::WIN_TXBUF;

    // ==================================================
    // Bit-rate divider
    // ==================================================
    logic [5:0] div_r;
    logic bit_en;
    assign bit_en = (div_r == 6'(mbd_pkg::BIT_CYC - 1));
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) div_r <= 6'h0;
        else div_r <= bit_en ? 6'h0 : div_r + 6'h1;
    end

    // ==================================================
    // Sequencer state
    // ==================================================
    mbd_pkg::mbd_state_t state_r;
    localparam mbd_pkg::mbd_state_t ST_IDLE = mbd_pkg::ST_IDLE;
    localparam mbd_pkg::mbd_state_t ST_BACKOFF = mbd_pkg::ST_BACKOFF;
    localparam mbd_pkg::mbd_state_t ST_CCA = mbd_pkg::ST_CCA;
    localparam mbd_pkg::mbd_state_t ST_TURN = mbd_pkg::ST_TURN;
    localparam mbd_pkg::mbd_state_t ST_TX = mbd_pkg::ST_TX;
    localparam mbd_pkg::mbd_state_t ST_ACKWAIT = mbd_pkg::ST_ACKWAIT;
    logic [15:0] cnt_r;
    logic [2:0] nb_r;
    logic [2:0] be_r;
    logic [2:0] retry_r;
    logic is_ack_r;
    logic [7:0] ack_seq_r;
    logic ack_pend_r;
    logic ack_match_r;
    logic [15:0] lfsr_r;
    logic [15:0] crc_r;
    logic [6:0] byte_idx_r;
    logic [2:0] bit_idx_r;

    wire [2:0] max_retry = txcfg_r[10:8];
    wire [6:0] tx_len = txcfg_r[6:0];
    wire ack_req = fctl_r[mbd_pkg::FC_ACKREQ];
    wire [6:0] body_bytes = is_ack_r ? mbd_pkg::ACK_BYTES : mbd_pkg::HDR_BYTES + tx_len;
    wire in_fcs = (byte_idx_r >= body_bytes);
    wire tx_last = (byte_idx_r == body_bytes + 7'h1) && (bit_idx_r == 3'h7);
    wire [6:0] pay_idx = byte_idx_r - mbd_pkg::HDR_BYTES;
    wire [7:0] rnd_mask = 8'((9'h1 << be_r) - 9'h1);
    wire [15:0] bo_load = 16'({8'h0, lfsr_r[7:0] & rnd_mask} * mbd_pkg::BO_TICKS) + 16'h1;
    wire [1:0] cca_mode = ctrl_r[mbd_pkg::CTL_CCA_LSB +: 2];
    logic [7:0] tx_byte;
    logic cca_busy;

    always_comb begin
        tx_byte = txbuf[pay_idx[5:0]];
        if (is_ack_r) begin
            case (byte_idx_r[1:0])
                2'h0: tx_byte = {5'h0, mbd_pkg::FT_ACK};
                2'h1: tx_byte = 8'h00;
                default: tx_byte = ack_seq_r;
            endcase
        end else if (byte_idx_r < mbd_pkg::HDR_BYTES) begin
            case (byte_idx_r[2:0])
                3'h0: tx_byte = fctl_r[7:0];
                3'h1: tx_byte = fctl_r[15:8];
                3'h2: tx_byte = txcfg_r[23:16];
                3'h3: tx_byte = dest_r[7:0];
                default: tx_byte = dest_r[15:8];
            endcase
        end
    end

    always_comb begin
        case (mbd_pkg::mbd_cca_t'(cca_mode))
            mbd_pkg::CCA_ED: cca_busy = cca_ed_i;
            mbd_pkg::CCA_CS: cca_busy = cca_cs_i;
            mbd_pkg::CCA_ED_AND_CS: cca_busy = cca_ed_i & cca_cs_i;
            default: cca_busy = cca_ed_i | cca_cs_i;
        endcase
    end

    wire tx_bit = in_fcs ? crc_r[0] : tx_byte[bit_idx_r];
    wire crc_fb = crc_r[0] ^ tx_bit;

    // ==================================================
    // Transmit, CSMA/CA and acknowledgement sequencer
    // ==================================================
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= ST_IDLE;
            cnt_r <= 16'h0;
            nb_r <= 3'h0;
            be_r <= mbd_pkg::MIN_BE;
            retry_r <= 3'h0;
            is_ack_r <= 1'b0;
            crc_r <= 16'h0;
            byte_idx_r <= 7'h0;
            bit_idx_r <= 3'h0;
            tx_on_o <= 1'b0;
            tx_bit_o <= 1'b0;
            tx_bit_vld_o <= 1'b0;
            tx_ok_r <= 1'b0;
            tx_fail_r <= 1'b0;
            irq_ack_o <= 1'b0;
        end else begin
            tx_bit_vld_o <= 1'b0;
            irq_ack_o <= 1'b0;
            if (wr_stat && reg_wdata_i[mbd_pkg::ST_TX_OK]) tx_ok_r <= 1'b0;
            if (wr_stat && reg_wdata_i[mbd_pkg::ST_TX_FAIL]) tx_fail_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (ack_pend_r) begin
                        is_ack_r <= 1'b1;
                        cnt_r <= mbd_pkg::TURN_TICKS;
                        state_r <= ST_TURN;
                    end else if (tx_req_r) begin
                        is_ack_r <= 1'b0;
                        retry_r <= 3'h0;
                        nb_r <= 3'h0;
                        be_r <= mbd_pkg::MIN_BE;
                        cnt_r <= 16'h1;
                        state_r <= ST_BACKOFF;
                    end
                end
                ST_BACKOFF, ST_TURN: begin
                    if (bit_en) begin
                        cnt_r <= cnt_r - 16'h1;
                        if (cnt_r == 16'h1 && state_r == ST_TURN) begin
                            state_r <= ST_TX;
                            tx_on_o <= 1'b1;
                        end else if (cnt_r == 16'h1) begin
                            cnt_r <= mbd_pkg::CCA_TICKS;
                            state_r <= ST_CCA;
                        end
                    end
                    crc_r <= 16'h0;
                    byte_idx_r <= 7'h0;
                    bit_idx_r <= 3'h0;
                end
                ST_CCA: begin
                    if (bit_en) begin
                        cnt_r <= cnt_r - 16'h1;
                        if (cnt_r == 16'h1 && !cca_busy) begin
                            state_r <= ST_TX;
                            tx_on_o <= 1'b1;
                        end else if (cnt_r == 16'h1 && nb_r == mbd_pkg::MAX_NB) begin
                            tx_fail_r <= 1'b1;
                            state_r <= ST_IDLE;
                        end else if (cnt_r == 16'h1) begin
                            nb_r <= nb_r + 3'h1;
                            be_r <= (be_r == mbd_pkg::MAX_BE) ? be_r : be_r + 3'h1;
                            cnt_r <= bo_load;
                            state_r <= ST_BACKOFF;
                        end
                    end
                end
                ST_TX: begin
                    if (bit_en) begin
                        tx_bit_o <= tx_bit;
                        tx_bit_vld_o <= 1'b1;
                        bit_idx_r <= bit_idx_r + 3'h1;
                        if (bit_idx_r == 3'h7) byte_idx_r <= byte_idx_r + 7'h1;
                        if (in_fcs) crc_r <= {1'b0, crc_r[15:1]};
                        else crc_r <= {1'b0, crc_r[15:1]} ^ (crc_fb ? mbd_pkg::CRC_POLY : 16'h0);
                        if (tx_last) begin
                            tx_on_o <= 1'b0;
                            state_r <= ST_IDLE;
                            if (is_ack_r) irq_ack_o <= ctrl_r[mbd_pkg::CTL_IRQ_ACK];
                            else if (ack_req) begin
                                cnt_r <= mbd_pkg::ACKW_TICKS;
                                state_r <= ST_ACKWAIT;
                            end else tx_ok_r <= 1'b1;
                        end
                    end
                end
                ST_ACKWAIT: begin
                    if (ack_match_r) begin
                        tx_ok_r <= 1'b1;
                        state_r <= ST_IDLE;
                    end else if (bit_en) begin
                        cnt_r <= cnt_r - 16'h1;
                        if (cnt_r == 16'h1 && retry_r == max_retry) begin
                            tx_fail_r <= 1'b1;
                            state_r <= ST_IDLE;
                        end else if (cnt_r == 16'h1) begin
                            retry_r <= retry_r + 3'h1;
                            nb_r <= 3'h0;
                            be_r <= mbd_pkg::MIN_BE;
                            cnt_r <= 16'h1;
                            state_r <= ST_BACKOFF;
                        end
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // ==================================================
    // Protocol timer and random source
    // ==================================================
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tmr_r <= 16'h0;
            tmr_arm_r <= 1'b0;
            tx_req_r <= 1'b0;
            lfsr_r <= 16'hace1;
        end else begin
            lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
            if (wr_tmr) begin
                tmr_r <= reg_wdata_i[15:0];
                tmr_arm_r <= 1'b1;
            end else if (tmr_arm_r && bit_en) begin
                tmr_r <= tmr_r - 16'h1;
                if (tmr_r == 16'h0) begin
                    tmr_arm_r <= 1'b0;
                    tmr_r <= 16'h0;
                    tx_req_r <= 1'b1;
                end
            end
            // A launch request left over from a busy period is taken on the next idle.
            if (state_r == ST_IDLE && !ack_pend_r && tx_req_r) tx_req_r <= 1'b0;
        end
    end

    // ==================================================
    // Receive path
    // ==================================================
    logic [7:0] rx_sh_r;
    logic [2:0] rx_bits_r;
    logic [15:0] rx_crc_r;
    logic [7:0] rx_fc_r;
    logic [7:0] rx_seq_r;
    wire rx_byte = rx_bit_vld_i && rx_bits_r == 3'h7;
    wire [7:0] rx_new = {rx_bit_i, rx_sh_r[7:1]};
    wire rx_crc_fb = rx_crc_r[0] ^ rx_bit_i;
    wire rx_is_ack = rx_fc_r[2:0] == mbd_pkg::FT_ACK;
    wire rx_good = rx_end_i && rx_crc_r == 16'h0;

    always_ff @(posedge core_clk_i) begin
        if (rx_byte && rx_len_r < 7'(mbd_pkg::BUF_DEPTH)) rxbuf[rx_len_r[5:0]] <= rx_new;
        if (wr_txbuf) txbuf[reg_addr_i[5:0]] <= reg_wdata_i[7:0];
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rx_sh_r <= 8'h0;
            rx_bits_r <= 3'h0;
            rx_crc_r <= 16'h0;
            rx_fc_r <= 8'h0;
            rx_seq_r <= 8'h0;
            rx_len_r <= 7'h0;
            rx_done_r <= 1'b0;
            crc_ok_r <= 1'b0;
            lqi_r <= 8'h0;
            ack_pend_r <= 1'b0;
            ack_match_r <= 1'b0;
            ack_seq_r <= 8'h0;
            irq_rx_o <= 1'b0;
        end else begin
            irq_rx_o <= 1'b0;
            ack_match_r <= 1'b0;
            if (wr_stat && reg_wdata_i[mbd_pkg::ST_RX_DONE]) rx_done_r <= 1'b0;
            if (rx_bit_vld_i) begin
                rx_sh_r <= rx_new;
                rx_bits_r <= rx_bits_r + 3'h1;
                rx_crc_r <= {1'b0, rx_crc_r[15:1]} ^ (rx_crc_fb ? mbd_pkg::CRC_POLY : 16'h0);
            end
            if (rx_byte) begin
                if (rx_len_r == 7'h0) rx_fc_r <= rx_new;
                if (rx_len_r == 7'h2) rx_seq_r <= rx_new;
                if (rx_len_r != 7'h7f) rx_len_r <= rx_len_r + 7'h1;
            end
            if (state_r == ST_TURN) ack_pend_r <= 1'b0;
            if (rx_end_i) begin
                crc_ok_r <= rx_crc_r == 16'h0;
                lqi_r <= lqi_i;
                rx_done_r <= 1'b1;
                irq_rx_o <= ctrl_r[mbd_pkg::CTL_IRQ_RX];
                rx_bits_r <= 3'h0;
                rx_crc_r <= 16'h0;
                if (rx_good && rx_is_ack && state_r == ST_ACKWAIT) ack_match_r <= rx_seq_r == txcfg_r[23:16];
                if (rx_good && !rx_is_ack && rx_fc_r[mbd_pkg::FC_ACKREQ] && ctrl_r[mbd_pkg::CTL_AUTOACK]) begin
                    ack_pend_r <= 1'b1;
                    ack_seq_r <= rx_seq_r;
                end
            end else if (rx_busy_i && !rx_bit_vld_i && rx_bits_r == 3'h0 && rx_done_r == 1'b0) begin
                rx_len_r <= rx_len_r;
            end
            // A new frame restarts the byte count only while the receiver is switched off (CTL_RX_ON clear).
            if (rx_end_i) rx_len_r <= rx_len_r;
            else if (rx_busy_i && !rx_bit_vld_i && rx_len_r != 7'h0 && rx_bits_r == 3'h0 && !ctrl_r[0])
                rx_len_r <= 7'h0;
        end
    end

    // ==================================================
    // Antenna diversity
    // ==================================================
    logic [8:0] ed_cnt_r;
    logic [8:0] pre_age_r;
    logic sw_pend_r;
    logic ant_rx_r;
    wire rxdiv_run = ctrl_r[mbd_pkg::CTL_RXDIV] && ctrl_r[mbd_pkg::CTL_RX_ON] && state_r == ST_IDLE;
    wire ed_tick = ed_cnt_r == 9'(mbd_pkg::ED_CYC - 1);
    wire pre_recent = pre_age_r < 9'(mbd_pkg::ED_CYC);
    wire tx_ant = ctrl_r[mbd_pkg::CTL_TXDIV] & retry_r[0];
    wire ant_sel = tx_ant ^ ant_rx_r;

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ed_cnt_r <= 9'h0;
            pre_age_r <= 9'(mbd_pkg::ED_CYC);
            sw_pend_r <= 1'b0;
            ant_rx_r <= 1'b0;
            ed_req_o <= 1'b0;
            antenna_select_primary_o <= 1'b0;
            antenna_select_inverse_o <= 1'b0;
        end else begin
            ed_cnt_r <= (!rxdiv_run || ed_tick) ? 9'h0 : ed_cnt_r + 9'h1;
            ed_req_o <= rxdiv_run && ed_tick;
            if (preamble_ok_i) pre_age_r <= 9'h0;
            else if (pre_pend_age(pre_age_r)) pre_age_r <= pre_age_r + 9'h1;
            if (ed_valid_i && rxdiv_run && ed_level_i < edthr_r && pre_recent) sw_pend_r <= 1'b1;
            // defer during receive or ack wait
            if (sw_pend_r && !rx_busy_i && state_r != ST_ACKWAIT) begin
                sw_pend_r <= 1'b0;
                ant_rx_r <= ~ant_rx_r;
            end
            antenna_select_primary_o <= ant_sel;
            antenna_select_inverse_o <= ctrl_r[mbd_pkg::CTL_INV_EN] & ~ant_sel;
        end
    end

    function automatic logic pre_pend_age(input logic [8:0] age);
        pre_pend_age = age < 9'(mbd_pkg::ED_CYC);
    endfunction : pre_pend_age

    // ==================================================
    // Register port
    // ==================================================
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_r <= mbd_pkg::CTRL_RST;
            txcfg_r <= 32'h0000_0000;
            dest_r <= 16'hffff;
            fctl_r <= 16'h0000;
            edthr_r <= mbd_pkg::EDTHR_RST;
        end else begin
            if (wr_ctrl) ctrl_r <= reg_wdata_i;
            if (wr_txcfg) txcfg_r <= reg_wdata_i;
            if (wr_dest) dest_r <= reg_wdata_i[15:0];
            if (wr_fctl) fctl_r <= reg_wdata_i[15:0];
            if (wr_thr) edthr_r <= reg_wdata_i[7:0];
        end
    end

    wire [31:0] status_w = {5'h0, retry_r, 1'b0, rx_len_r, lqi_r, 2'h0, ant_sel, crc_ok_r,
                            rx_done_r, tx_fail_r, tx_ok_r, state_r != ST_IDLE};
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0000_0000;
        case (reg_addr_i)
            mbd_pkg::REG_CTRL: rd_val = ctrl_r;
            mbd_pkg::REG_TXCFG: rd_val = txcfg_r;
            mbd_pkg::REG_DEST: rd_val = {16'h0, dest_r};
            mbd_pkg::REG_TIMER: rd_val = {15'h0, tmr_arm_r, tmr_r};
            mbd_pkg::REG_EDTHR: rd_val = {24'h0, edthr_r};
            mbd_pkg::REG_STATUS: rd_val = status_w;
            mbd_pkg::REG_FCTL: rd_val = {16'h0, fctl_r};
            default: begin
                if (reg_addr_i[7:6] == mbd_pkg::WIN_TXBUF) rd_val = {24'h0, txbuf[reg_addr_i[5:0]]};
                if (reg_addr_i[7:6] == mbd_pkg::WIN_RXBUF) rd_val = {24'h0, rxbuf[reg_addr_i[5:0]]};
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) reg_rdata_o <= 32'h0000_0000;
        else reg_rdata_o <= reg_rd_i ? rd_val : 32'h0000_0000;
    end
endmodule : mbd_baseband

//--- bench/mbd_checker_sva.sv
`timescale 1ns/10ps
module mbd_checker_sva (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic tx_on_o,
    input wire logic tx_bit_vld_o,
    input wire logic ed_req_o,
    input wire logic rx_end_i,
    input wire logic rx_busy_i,
    input wire logic irq_rx_o,
    input wire logic irq_ack_o,
    input wire logic antenna_select_primary_o,
    input wire logic antenna_select_inverse_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);
    // Ticks repeat every 40 or 400 clocks, so none may recur within eight.
    sequence quiet_s(s);
        !s [*8];
    endsequence
    inv_sel_a: assert property (antenna_select_inverse_o |-> !antenna_select_primary_o) else $error("sel clash");
    rd_zero_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000) else $error("stray read data");
    bit_gap_a: assert property (tx_bit_vld_o |=> quiet_s(tx_bit_vld_o)) else $error("bit tick too soon");
    bit_on_a: assert property (tx_bit_vld_o |-> $past(tx_on_o)) else $error("bit outside frame");
    ed_gap_a: assert property (ed_req_o |=> quiet_s(ed_req_o)) else $error("energy request too soon");
    ed_idle_a: assert property (ed_req_o |-> !tx_on_o) else $error("energy request in transmit");
    irq_rx_a: assert property (irq_rx_o |-> $past(rx_end_i)) else $error("rx irq without frame end");
    irq_ack_a: assert property (irq_ack_o |-> !tx_on_o ##1 !irq_ack_o) else $error("ack irq not a pulse");
    rx_hold_a: assert property (rx_busy_i && $past(rx_busy_i) && $past(rx_busy_i, 2)
        |-> $stable(antenna_select_primary_o)) else $error("rx switch");
endmodule : mbd_checker_sva
bind mbd_baseband mbd_checker_sva u_chk (.core_clk_i, .rstn_i, .reg_rd_i, .reg_rdata_o, .tx_on_o, .tx_bit_vld_o,
    .ed_req_o, .rx_end_i, .rx_busy_i, .irq_rx_o, .irq_ack_o, .antenna_select_primary_o, .antenna_select_inverse_o);

//--- bench/mbd_modem_model.sv
`timescale 1ns/10ps
module mbd_modem_model (
    input wire logic clk_i,
    input wire logic tx_bit_i,
    input wire logic tx_vld_i,
    input wire logic ed_req_i,
    input wire logic [7:0] ed_lvl_i,
    output logic ed_valid_o = 1'b0,
    output logic [7:0] ed_level_o = 8'h00,
    output logic [7:0] byte_o = 8'h00,
    output logic byte_stb_o = 1'b0
);
    logic [2:0] cnt_r = 3'h0;
    always_ff @(posedge clk_i) begin
        byte_stb_o <= tx_vld_i && cnt_r == 3'h7;
        ed_valid_o <= ed_req_i;
        // Between answers the level bus inverts its last value every clock, so the level matches only in the ed_valid_o cycle and every second clock after it.
        ed_level_o <= ed_req_i ? ed_lvl_i : ~ed_level_o;
        if (tx_vld_i) begin
            byte_o <= {tx_bit_i, byte_o[7:1]};
            cnt_r <= cnt_r + 3'h1;
        end
    end
endmodule : mbd_modem_model

//--- bench/mac_baseband_antenna_diversity_tb.sv
`timescale 1ns/10ps
module mac_baseband_antenna_diversity_tb;
    logic core_clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, rx_busy_i = 1'b0, rd_d = 1'b0;
    logic preamble_ok_i = 1'b0, ed_valid_i, tx_on_o, tx_bit_o, tx_bit_vld_o, ed_req_o, irq_rx_o, irq_ack_o, stb;
    logic antenna_select_primary_o, antenna_select_inverse_o, cca_ed_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, lqi_i = 8'h00, lvl = 8'h10, ed_level_i, by;
    logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o;
    logic [63:0] eq[$];
    logic [7:0] fr[$];
    logic [15:0] crc = 16'h0000;
    int miscompares = 0, tests_run = 0, seed = 73;
    always #50 core_clk_i = ~core_clk_i;
    mbd_baseband DUT (.core_clk_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .tx_on_o, .tx_bit_o, .tx_bit_vld_o, .rx_bit_i(1'b0), .rx_bit_vld_i(1'b0), .rx_busy_i, .rx_end_i(1'b0),
        .lqi_i, .preamble_ok_i, .cca_ed_i, .cca_cs_i(1'b0), .ed_req_o, .ed_valid_i, .ed_level_i,
        .irq_rx_o, .irq_ack_o, .antenna_select_primary_o, .antenna_select_inverse_o);
    mbd_modem_model u_mdm (.clk_i(core_clk_i), .tx_bit_i(tx_bit_o), .tx_vld_i(tx_bit_vld_o), .ed_req_i(ed_req_o),
        .ed_lvl_i(lvl), .ed_valid_o(ed_valid_i), .ed_level_o(ed_level_i), .byte_o(by), .byte_stb_o(stb));
    function automatic logic [15:0] crc_b(input logic [15:0] c, input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            c = (c[0] ^ b[i]) ? (c >> 1) ^ mbd_pkg::CRC_POLY : c >> 1;
        end
        return c;
    endfunction : crc_b
    task automatic chk(input logic [63:0] e, input logic [31:0] g);
        tests_run++;
        if ((g & e[63:32]) !== e[31:0]) begin
            miscompares++;
            $display("wrong value at %0t: expected %h got %h", $time, e[31:0], g);
        end
    endtask : chk
    // A read carries its expected value on the idle write-data lines.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = '1);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= w;
        reg_rd_i <= !w;
        if (!w) eq.push_back({m, d});
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
    endtask : acc
    task automatic test_done();
        $display("%0d checks, %0d miscompares", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    always @(posedge core_clk_i) begin
        rd_d <= reg_rd_i;
        if (rd_d) chk(eq.pop_front(), reg_rdata_o);
        if (stb === 1'b1) chk({32'h0000_00ff, 24'h00_0000, fr.pop_front()}, {24'h00_0000, by});
    end
    initial begin
        #(30000 * 100);
        miscompares++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        lqi_i <= 8'($random(seed));
        acc(1'b0, mbd_pkg::REG_EDTHR, 32'h0000_0040);
        acc(1'b0, mbd_pkg::REG_DEST, 32'h0000_ffff);
        acc(1'b0, 8'h07, 32'h0000_0000);
        $display("test reset done");
        fr = {8'h01, 8'h00};
        repeat (4) fr.push_back(8'($random(seed)));
        acc(1'b1, mbd_pkg::REG_FCTL, 32'h0000_0001);
        acc(1'b1, mbd_pkg::REG_CTRL, 32'h0000_0200);
        cca_ed_i <= 1'b1;
        acc(1'b1, mbd_pkg::REG_TXCFG, {8'h00, fr[2], 16'h0001});
        acc(1'b1, mbd_pkg::REG_DEST, {16'h0000, fr[4], fr[3]});
        acc(1'b1, 8'h40, {24'h00_0000, fr[5]});
        foreach (fr[i]) crc = crc_b(crc, fr[i]);
        fr.push_back(crc[7:0]);
        fr.push_back(crc[15:8]);
        acc(1'b1, mbd_pkg::REG_TIMER, 32'h0000_0000);
        for (int i = 0; i < 9000 && fr.size() > 0; i++) @(posedge core_clk_i);
        repeat (50) @(posedge core_clk_i);
        chk(64'hffff_ffff_0000_0000, 32'(fr.size()));
        acc(1'b0, mbd_pkg::REG_STATUS, 32'h0000_0002, 32'h0700_0007);
        $display("test transmit done");
        acc(1'b1, mbd_pkg::REG_CTRL, 32'h0000_0043);
        repeat (900) @(posedge core_clk_i);
        acc(1'b0, mbd_pkg::REG_STATUS, 32'h0000_0000, 32'h0000_0020);
        chk({32'h0000_0003, 32'h0000_0002}, {30'h0, antenna_select_inverse_o, antenna_select_primary_o});
        rx_busy_i <= 1'b1;
        preamble_ok_i <= 1'b1;
        @(posedge core_clk_i);
        preamble_ok_i <= 1'b0;
        repeat (450) @(posedge core_clk_i);
        acc(1'b0, mbd_pkg::REG_STATUS, 32'h0000_0000, 32'h0000_0020);
        rx_busy_i <= 1'b0;
        repeat (20) @(posedge core_clk_i);
        acc(1'b0, mbd_pkg::REG_STATUS, 32'h0000_0020, 32'h0000_0020);
        chk({32'h0000_0003, 32'h0000_0001}, {30'h0, antenna_select_inverse_o, antenna_select_primary_o});
        repeat (3) @(posedge core_clk_i);
        $display("test diversity done");
        test_done();
    end
endmodule : mac_baseband_antenna_diversity_tb
